// ==== hdl/fdd_status.sv ====
// Flexible disk drive status outputs, head tracking and write gating
//
// Summary of operation
// RL1 - Index line goes low once per revolution, nominal 3 ms every 200 ms.
// RL2 - Read line carries combined clock and data pulses from the read head.
// RL3 - Home-track line is low while the head is on track 00, else high.
// RL4 - Write-inhibit line is low while a protected diskette is installed.
// RL5 - No writing reaches the medium while the diskette is write protected.
// RL6 - Optional ready line goes low only when a proper diskette is spinning.
// RL7 - Host spaces step pulses 6 ms (48 tpi) or 3 ms (96 tpi) apart.
// RL8 - Host waits 21 ms or 18 ms after last step before reading.
// RL9 - Host write pulses are 250 ns wide with tightly held spacings.
// RL10 - Unit number comes from a jumper; drive answers only its select line.
// RL11 - Test jumper keeps the output lines active regardless of selects.
// RL12 - Only the selected drive responds, drives outputs and lights its lamp; with the test jumper an unselected drive also drives its outputs.
// RL13 - Write gate is ignored while protected or while not selected.
// RL14 - Unselected drive without test jumper holds all status lines high.
`timescale 1ns/100ps
module fdd_status
    import fdd_pkg::*;
#(
    parameter int INDEX_CYC = INDEX_PULSE_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Host cable inputs, active low
    input wire logic [NUM_SELECTS-1:0] select_n,
    input wire logic write_gate_n,
    input wire logic write_data_n,
    input wire logic step_n,
    input wire logic direction_n,
    // Mechanism sensors
    input wire logic index_hole,
    input wire logic read_flux,
    input wire logic home_sensor,
    input wire logic protect_notch,
    input wire logic disk_inserted,
    input wire logic spindle_at_speed,
    // Jumpers
    input wire logic [1:0] unit_jumper,
    input wire logic test_output_force,
    // Host cable outputs, active low
    output logic index_n,
    output logic read_data_n,
    output logic track00_n,
    output logic write_protect_n,
    output logic ready_n,
    // Drive internals
    output logic led_on,
    output logic head_write_en,
    output logic head_flux,
    output logic [6:0] head_track
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic [SYNC_W-1:0] prev_r;
    logic [SYNC_W-1:0] raw_w;

    assign raw_w = {select_n, write_gate_n, write_data_n, step_n, direction_n,
                    index_hole, read_flux, home_sensor, protect_notch, disk_inserted,
                    spindle_at_speed, test_output_force, unit_jumper, 1'b0};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_r <= SYNC_RESET;
            sync_r <= SYNC_RESET;
            prev_r <= SYNC_RESET;
        end else if (clk_en) begin
            meta_r <= raw_w;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic [NUM_SELECTS-1:0] sel_n_s;
    logic wg_n_s, wd_n_s, step_n_s, dir_n_s, hole_s, flux_s, home_s, notch_s;
    logic disk_s, spin_s, force_s, spare_s;
    logic [1:0] jumper_s;
    logic wd_n_p, step_n_p, hole_p, flux_p;

    assign {sel_n_s, wg_n_s, wd_n_s, step_n_s, dir_n_s, hole_s, flux_s, home_s, notch_s,
            disk_s, spin_s, force_s, jumper_s, spare_s} = sync_r;
    assign wd_n_p = prev_r[12];
    assign step_n_p = prev_r[11];
    assign hole_p = prev_r[9];
    assign flux_p = prev_r[8];

    // ------------------------------------------------------------
    // Addressing and gating
    // ------------------------------------------------------------
    logic [1:0] unit_r;
    logic selected_w;
    logic active_w;
    logic write_ok_w;

    assign selected_w = !sel_n_s[unit_r]; // [RL10]
    assign active_w = selected_w | force_s; // [RL11] [RL12]
    assign write_ok_w = selected_w & !wg_n_s & !notch_s; // [RL5] [RL13]

    // ------------------------------------------------------------
    // Pulse forming
    // ------------------------------------------------------------
    pulse_if idx_if ();
    pulse_if rd_if ();

    // Index pulse length is set here, not by the hole width, so the host sees
    // the same pulse whatever the sensor alignment.
    assign idx_if.fire = hole_s & !hole_p; // [RL1]
    assign rd_if.fire = flux_s & !flux_p; // [RL2]

    pulse_stretch #(.CYCLES(INDEX_CYC)) u_idx (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .p(idx_if.stretch)
    );

    pulse_stretch #(.CYCLES(READ_PULSE_CYC)) u_rd (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .p(rd_if.stretch)
    );

    // ------------------------------------------------------------
    // Head position
    // ------------------------------------------------------------
    logic [6:0] track_r;
    logic [6:0] track_nxt;
    logic step_w;

    // Stepping is only counted when this unit is addressed
    assign step_w = selected_w & !step_n_s & step_n_p;
    assign track_nxt = home_s ? TRACK_HOME :
                       !step_w ? track_r :
                       !dir_n_s ? ((track_r == TRACK_LAST) ? track_r : track_r + 7'h01) :
                       ((track_r == TRACK_HOME) ? track_r : track_r - 7'h01);

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic flux_nxt;
    assign flux_nxt = (write_ok_w & wd_n_p & !wd_n_s) ? !head_flux : head_flux;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            unit_r <= UNIT_DEFAULT; // [RL10]
            track_r <= TRACK_HOME;
            index_n <= 1'b1;
            read_data_n <= 1'b1;
            track00_n <= 1'b1;
            write_protect_n <= 1'b1;
            ready_n <= 1'b1;
            led_on <= 1'b0;
            head_write_en <= 1'b0;
            head_flux <= 1'b0;
        end else if (clk_en) begin
            unit_r <= jumper_s;
            track_r <= track_nxt;
            index_n <= !(active_w & idx_if.busy); // [RL1] [RL14]
            read_data_n <= !(active_w & rd_if.busy); // [RL2] [RL14]
            track00_n <= !(active_w & (track_r == TRACK_HOME)); // [RL3] [RL14]
            write_protect_n <= !(active_w & notch_s); // [RL4] [RL14]
            ready_n <= !(active_w & disk_s & spin_s); // [RL6] [RL14]
            led_on <= selected_w; // [RL12]
            head_write_en <= write_ok_w; // [RL5] [RL13]
            head_flux <= flux_nxt;
        end
    end

    assign head_track = track_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_index_low;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && active_w && idx_if.busy) |=> !index_n;
    endproperty
    a_index_low: assert property (p_index_low) else $error("index not low"); // [RL1]

    property p_read_pulse;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && active_w && rd_if.fire) ##1 (clk_en && active_w) |=> !read_data_n;
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read pulse missing"); // [RL2]

    property p_home_flag;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && active_w) |=> (track00_n == ($past(track_r) != TRACK_HOME));
    endproperty
    a_home_flag: assert property (p_home_flag) else $error("home flag wrong"); // [RL3]

    property p_protect_flag;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && active_w && notch_s) |=> !write_protect_n;
    endproperty
    a_protect_flag: assert property (p_protect_flag) else $error("protect not shown"); // [RL4]

    property p_no_write_protected;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && notch_s) |=> !head_write_en;
    endproperty
    a_no_write_protected: assert property (p_no_write_protected) // [RL5]
        else $error("write while protected");

    property p_ready_cause;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && !(disk_s && spin_s)) |=> ready_n;
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without disk"); // [RL6]

    property p_select_lamp;
        @(posedge core_clk) disable iff (sys_rst)
        clk_en |=> (led_on == !$past(sel_n_s[unit_r]));
    endproperty
    a_select_lamp: assert property (p_select_lamp) else $error("lamp not tied to select"); // [RL10]

    property p_test_force;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && force_s && notch_s) |=> !write_protect_n;
    endproperty
    a_test_force: assert property (p_test_force) else $error("test jumper ignored"); // [RL11]

    property p_idle_high;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && !active_w) |=> (index_n && read_data_n && track00_n && write_protect_n
                                   && ready_n && !led_on);
    endproperty
    a_idle_high: assert property (p_idle_high) // [RL12] [RL14]
        else $error("unselected drive active");

    property p_gate_ignored;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && (wg_n_s || !selected_w)) |=> !head_write_en;
    endproperty
    a_gate_ignored: assert property (p_gate_ignored) // [RL13]
        else $error("write gate not ignored");
endmodule

// ==== hdl/fdd_pkg.sv ====
// Constants shared by the drive status and timing logic
package fdd_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int INDEX_PULSE_MS = 3;
    localparam int INDEX_PULSE_CYC = INDEX_PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int INDEX_PERIOD_MS = 200;
    localparam int READ_PULSE_NS = 1000;
    localparam int READ_PULSE_CYC = READ_PULSE_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Drive addressing and head position
    // ------------------------------------------------------------
    localparam int NUM_SELECTS = 4;
    localparam logic [1:0] UNIT_DEFAULT = 2'h0;
    localparam logic [6:0] TRACK_HOME = 7'h00;
    localparam logic [6:0] TRACK_LAST = 7'h4f;
    localparam int SYNC_W = 18;
    // Idle levels: selects, gate, data, step and direction high, the rest low
    localparam logic [SYNC_W-1:0] SYNC_RESET = 18'h3fc00;
endpackage

// ==== hdl/pulse_if.sv ====
// Trigger and busy pair between the drive core and a pulse stretcher
`timescale 1ns/100ps
interface pulse_if;
    logic fire;
    logic busy;
    modport core (output fire, input busy);
    modport stretch (input fire, output busy);
endinterface

// ==== hdl/pulse_stretch.sv ====
// Stretches a one-cycle trigger into a pulse of fixed length
`timescale 1ns/100ps
module pulse_stretch #(
    parameter int CYCLES = 100
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Trigger and pulse
    pulse_if.stretch p
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // A new trigger restarts the pulse so close edges never merge short
    assign cnt_nxt = p.fire ? LOAD : ((cnt_r != '0) ? cnt_r - CW'(1) : cnt_r);
    assign p.busy = (cnt_r != '0);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== verif/host_model.sv ====
// Host controller model: drive selects, stepping and write pulses
`timescale 1ns/100ps
module host_model #(
    parameter int STEP_GAP = 6,
    parameter int SETTLE = 21,
    parameter int WR_WIDTH = 25,
    parameter int WR_GAP = 400
) (
    // Clock
    input wire logic core_clk,
    // Cable to the drive
    output logic [3:0] select_n,
    output logic step_n,
    output logic direction_n,
    output logic write_gate_n,
    output logic write_data_n
);
    initial begin
        select_n = 4'hf;
        step_n = 1'b1;
        direction_n = 1'b1;
        write_gate_n = 1'b1;
        write_data_n = 1'b1;
    end

    task automatic sel(input logic [3:0] v);
        @(negedge core_clk) select_n = v;
        repeat (6) @(negedge core_clk);
    endtask

    // Direction settles a cycle before the first step edge
    task automatic do_steps(input int n, input logic dir_n);
        @(negedge core_clk) direction_n = dir_n;
        repeat (n) begin
            @(negedge core_clk) step_n = 1'b0;
            repeat (2) @(negedge core_clk);
            step_n = 1'b1;
            repeat (STEP_GAP) @(negedge core_clk);
        end
        repeat (SETTLE) @(negedge core_clk);
    endtask

    task automatic do_writes(input int n);
        @(negedge core_clk) write_gate_n = 1'b0;
        repeat (8) @(negedge core_clk);
        repeat (n) begin
            write_data_n = 1'b0;
            repeat (WR_WIDTH) @(negedge core_clk);
            write_data_n = 1'b1;
            repeat (WR_GAP - WR_WIDTH) @(negedge core_clk);
        end
        write_gate_n = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the drive status block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import fdd_pkg::*;
    logic core_clk = 0, sys_rst, clk_en, index_hole, read_flux;
    logic home_sensor, protect_notch, disk_inserted, spindle_at_speed;
    logic test_output_force, step_n, direction_n, write_gate_n, write_data_n;
    logic [1:0] unit_jumper;
    logic [5:0] cable_outs;
    logic [3:0] select_n;
    logic index_n, read_data_n, track00_n, write_protect_n, ready_n, led_on;
    logic head_write_en, head_flux, f0;
    logic [6:0] head_track;
    int err_count = 0, checked = 0, n;

    // ----------------------------------------
    // Clock, host and design
    // ----------------------------------------
    initial forever #5 core_clk = ~core_clk;
    host_model i_host_model (.core_clk(core_clk), .select_n(select_n), .step_n(step_n),
        .direction_n(direction_n), .write_gate_n(write_gate_n), .write_data_n(write_data_n));
    fdd_status #(.INDEX_CYC(20)) i_fdd_status (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .select_n(select_n), .write_gate_n(write_gate_n),
        .write_data_n(write_data_n), .step_n(step_n), .direction_n(direction_n),
        .index_hole(index_hole), .read_flux(read_flux), .home_sensor(home_sensor),
        .protect_notch(protect_notch), .disk_inserted(disk_inserted),
        .spindle_at_speed(spindle_at_speed), .unit_jumper(unit_jumper),
        .test_output_force(test_output_force), .index_n(index_n), .read_data_n(read_data_n),
        .track00_n(track00_n), .write_protect_n(write_protect_n), .ready_n(ready_n),
        .led_on(led_on), .head_write_en(head_write_en), .head_flux(head_flux),
        .head_track(head_track));
    assign cable_outs = {index_n, read_data_n, track00_n, write_protect_n, ready_n, led_on};

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wt(input int c);
        repeat (c) @(negedge core_clk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bounded wait for the pulse, then its length in cycles
    task automatic low_len(input bit rd);
        int k;
        n = 0;
        for (k = 0; k < 20 && (rd ? read_data_n : index_n) !== 1'b0; k++) wt(1);
        while ((rd ? read_data_n : index_n) === 1'b0 && n < 400) begin
            wt(1);
            n++;
        end
        if (k == 20 || n == 400) begin
            err_count++;
            end_sim();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_pulses();
        i_host_model.sel(4'he);
        index_hole = 1'b1;
        low_len(0);
        `CHK("index width", 20, n)
        index_hole = 1'b0;
        read_flux = 1'b1;
        low_len(1);
        `CHK("read width", READ_PULSE_CYC, n)
        read_flux = 1'b0;
    endtask

    task automatic t_track();
        i_host_model.do_steps(3, 1'b0);
        `CHK("track in", 7'h03, head_track)
        `CHK("home off", 1'b1, track00_n)
        i_host_model.do_steps(4, 1'b1);
        `CHK("track out", 7'h00, head_track)
        `CHK("home on", 1'b0, track00_n)
        i_host_model.do_steps(2, 1'b0);
        `CHK("track two", 7'h02, head_track)
        home_sensor = 1'b1;
        wt(5);
        `CHK("sensor home", 7'h00, head_track)
        `CHK("sensor flag", 1'b0, track00_n)
        home_sensor = 1'b0;
    endtask

    task automatic t_write();
        protect_notch = 1'b1;
        f0 = head_flux;
        wt(6);
        `CHK("protect", 1'b0, write_protect_n)
        fork
            i_host_model.do_writes(2);
            begin wt(20); `CHK("gate held", 1'b0, head_write_en) end
        join
        `CHK("blocked", f0, head_flux)
        protect_notch = 1'b0;
        fork
            i_host_model.do_writes(3);
            begin wt(20); `CHK("gate taken", 1'b1, head_write_en) end
        join
        `CHK("written", ~f0, head_flux)
        i_host_model.sel(4'hf);
        fork
            i_host_model.do_writes(2);
            begin wt(20); `CHK("gate unsel", 1'b0, head_write_en) end
        join
        `CHK("unselected", ~f0, head_flux)
    endtask

    task automatic t_ready_unit();
        i_host_model.sel(4'he);
        disk_inserted = 1'b1;
        wt(6);
        `CHK("not spinning", 1'b1, ready_n)
        spindle_at_speed = 1'b1;
        wt(6);
        `CHK("ready", 1'b0, ready_n)
        unit_jumper = 2'h2;
        protect_notch = 1'b1;
        wt(6);
        `CHK("other lamp", 1'b0, led_on)
        `CHK("other out", 1'b1, write_protect_n)
        i_host_model.do_steps(1, 1'b0);
        `CHK("no step", 7'h00, head_track)
        i_host_model.sel(4'hb);
        `CHK("own lamp", 1'b1, led_on)
        `CHK("own out", 1'b0, write_protect_n)
        i_host_model.sel(4'hf);
        test_output_force = 1'b1;
        wt(6);
        `CHK("forced out", 1'b0, write_protect_n)
        `CHK("forced home", 1'b0, track00_n)
        `CHK("forced lamp", 1'b0, led_on)
    endtask

    // Steps during a frozen enable are lost; a mid-run reset returns to idle
    task automatic t_freeze_reset();
        test_output_force = 1'b0;
        i_host_model.sel(4'hb);
        i_host_model.do_steps(2, 1'b0);
        `CHK("track before", 7'h02, head_track)
        clk_en = 1'b0;
        i_host_model.do_steps(1, 1'b0);
        clk_en = 1'b1;
        wt(4);
        `CHK("frozen track", 7'h02, head_track)
        sys_rst = 1'b1;
        wt(2);
        sys_rst = 1'b0;
        wt(1);
        `CHK("reset outs", 6'h3e, cable_outs)
        `CHK("reset track", 7'h00, head_track)
        wt(6);
        `CHK("reset home", 1'b0, track00_n)
    endtask

    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        {index_hole, read_flux, home_sensor, protect_notch} = 4'h0;
        {disk_inserted, spindle_at_speed, test_output_force} = 3'h0;
        unit_jumper = 2'h0;
        wt(4);
        sys_rst = 1'b0;
        wt(1);
        `CHK("idle outs", 6'h3e, cable_outs)
        t_pulses();
        t_track();
        t_write();
        t_ready_unit();
        t_freeze_reset();
        end_sim();
    end
endmodule
